// ### common/gpp_pkg.sv
// shared constants for the general-purpose port block
package gpp_pkg;
	// port register offsets
	localparam logic [7:0] OFS_DIR = 8'h00;
	localparam logic [7:0] OFS_OUT = 8'h04;
	localparam logic [7:0] OFS_IN = 8'h08;
	localparam logic [7:0] OFS_IRQ_LEVEL_CTRL = 8'h09;
	localparam logic [7:0] OFS_IRQ0_PIN_SELECT = 8'h0A;
	localparam logic [7:0] OFS_IRQ1_PIN_SELECT = 8'h0B;
	localparam logic [7:0] OFS_IRQ_FLAGS = 8'h0C;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h0D;
	localparam logic [7:0] OFS_PIN_CTRL = 8'h10;
	// port configuration offsets
	localparam logic [7:0] OFS_MULTI_PIN_MASK = 8'h40;
	localparam logic [7:0] OFS_VMAP_A = 8'h42;
	localparam logic [7:0] OFS_VMAP_B = 8'h43;
	// virtual port windows: four registers each
	localparam logic [7:0] OFS_VPORT = 8'h50;
	localparam logic [7:0] VP_DIR = 8'h00;
	localparam logic [7:0] VP_OUT = 8'h01;
	localparam logic [7:0] VP_IN = 8'h02;
	localparam logic [7:0] VP_FLAGS = 8'h03;
	localparam logic [7:0] OFS_UNMAPPED = 8'hFF;
	// field layout
	localparam int LVL0_LSB = 0;
	localparam int LVL1_LSB = 2;
	localparam logic [7:0] IRQ_LEVEL_CTRL_RW = 8'h0F;
	localparam logic [7:0] IRQ_FLAGS_RW = 8'h03;
	localparam int VMAP_W = 4;
	localparam int SENSE_W = 3;
	// index of this real port among all ports
	localparam logic [3:0] PORT_INDEX = 4'h0;
	// reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [1:0] RST_LEVEL = 2'h0;
	// per-pin input sense configuration
	typedef enum logic [2:0] {
		GPP_SENSE_BOTH = 3'b000,
		GPP_SENSE_RISE = 3'b001,
		GPP_SENSE_FALL = 3'b010,
		GPP_SENSE_LOW = 3'b011,
		GPP_SENSE_OFF = 3'b111
	} gpp_sense_e;
endpackage

// ### design/gpp_port.sv
// eight-pin port with two port interrupts, multi-pin configuration and virtual port map
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
// Notes on behaviour
// RULE1: input value register shows each enabled pin's level at bit n.
// RULE2: a pin with its input buffer disabled is not sampled and reads zero.
// RULE3: two 2-bit level fields enable port interrupts and pick their priority.
// RULE4: pin n feeds port interrupt 0 exactly when its select bit is one.
// RULE5: pin n feeds port interrupt 1 exactly when its select bit is one.
// RULE6: each pin's own control register decides which input condition is an event.
// RULE7: with multi-pin mask nonzero, a pin control write updates only masked pins.
// RULE8: the multi-pin mask clears itself right after any pin control write.
// RULE9: four 4-bit fields in two registers choose the real port per virtual port.
// RULE10: a virtual port maps direction, output, input value and interrupt flags.
// RULE11: a virtual access acts exactly like the same access to the real register.
// RULE12: upper four bits of the level control register are read-only zero.
// RULE13: port interrupt n fires only with nonzero level, a selected event and its flag.
// RULE14: each mapping value is a real port index; zero is the first port.
module gpp_port (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// register port
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata_q,
	// pins
	input wire logic [7:0] pin_in,
	output logic [7:0] pin_out_q,
	output logic [7:0] pin_oe_q,
	// interrupts
	output logic [1:0] irq0_level_q,
	output logic [1:0] irq1_level_q,
	output logic irq_q
);
	logic [7:0] sync1_q, sync2_q, sync3_q;
	logic [7:0] in_q, in_d;
	logic [7:0] dir_q, out_q;
	logic [7:0] lvl_ctrl_q, sel0_q, sel1_q;
	logic [1:0] flags_q, flags_d, irq_mask_q;
	logic [7:0] mpc_q;
	logic [7:0] vmap_a_q, vmap_b_q;
	logic [7:0] pin_ctrl_q [8];
	logic [7:0] eff;
	logic [7:0] pin_ev;
	logic [1:0] hit;
	logic pin_wr;
	logic [2:0] pin_idx;

	// virtual windows are folded onto real offsets so every side effect is shared
	always_comb begin
		logic [3:0] vsel;
		logic [7:0] real_ofs;
		vsel = 4'h0;
		real_ofs = gpp_pkg::OFS_UNMAPPED;
		eff = addr;
		if (addr[7:4] == gpp_pkg::OFS_VPORT[7:4]) begin
			unique case (addr[3:2])
				2'b00: vsel = vmap_a_q[3:0]; // RULE9
				2'b01: vsel = vmap_a_q[7:4]; // RULE9
				2'b10: vsel = vmap_b_q[3:0]; // RULE9
				2'b11: vsel = vmap_b_q[7:4]; // RULE9
			endcase
			unique case ({6'h00, addr[1:0]})
				gpp_pkg::VP_DIR: real_ofs = gpp_pkg::OFS_DIR; // RULE10
				gpp_pkg::VP_OUT: real_ofs = gpp_pkg::OFS_OUT; // RULE10
				gpp_pkg::VP_IN: real_ofs = gpp_pkg::OFS_IN; // RULE10
				default: real_ofs = gpp_pkg::OFS_IRQ_FLAGS; // RULE10
			endcase
			// other port indices belong to sibling ports, so this port stays silent
			eff = (vsel == gpp_pkg::PORT_INDEX) ? real_ofs : gpp_pkg::OFS_UNMAPPED; // RULE11 RULE14
		end
	end

	assign pin_wr = wr && (eff[7:3] == gpp_pkg::OFS_PIN_CTRL[7:3]);
	assign pin_idx = eff[2:0];

	// three-stage synchroniser; a change counts once stages two and three agree
	always_ff @(posedge clk) begin
		if (rst) begin
			sync1_q <= gpp_pkg::RST_BYTE;
			sync2_q <= gpp_pkg::RST_BYTE;
			sync3_q <= gpp_pkg::RST_BYTE;
		end else begin
			sync1_q <= pin_in;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
		end
	end

	// input value and per-pin sense events
	always_comb begin
		for (int n = 0; n < 8; n++) begin
			if (pin_ctrl_q[n][gpp_pkg::SENSE_W-1:0] == gpp_pkg::GPP_SENSE_OFF) begin
				in_d[n] = 1'b0; // RULE2
			end else if (sync2_q[n] == sync3_q[n]) begin
				in_d[n] = sync3_q[n]; // RULE1
			end else begin
				in_d[n] = in_q[n];
			end
			unique case (pin_ctrl_q[n][gpp_pkg::SENSE_W-1:0])
				gpp_pkg::GPP_SENSE_BOTH: pin_ev[n] = in_d[n] ^ in_q[n]; // RULE6
				gpp_pkg::GPP_SENSE_RISE: pin_ev[n] = in_d[n] & ~in_q[n]; // RULE6
				gpp_pkg::GPP_SENSE_FALL: pin_ev[n] = ~in_d[n] & in_q[n]; // RULE6
				gpp_pkg::GPP_SENSE_LOW: pin_ev[n] = ~in_d[n]; // RULE6
				default: pin_ev[n] = 1'b0;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			in_q <= gpp_pkg::RST_BYTE;
		end else begin
			in_q <= in_d;
		end
	end

	// direction and output value drive the pins straight from their flops
	always_ff @(posedge clk) begin
		if (rst) begin
			dir_q <= gpp_pkg::RST_BYTE;
			out_q <= gpp_pkg::RST_BYTE;
		end else if (wr) begin
			if (eff == gpp_pkg::OFS_DIR) begin
				dir_q <= wdata;
			end
			if (eff == gpp_pkg::OFS_OUT) begin
				out_q <= wdata;
			end
		end
	end

	assign pin_out_q = out_q;
	assign pin_oe_q = dir_q;

	// interrupt configuration
	always_ff @(posedge clk) begin
		if (rst) begin
			lvl_ctrl_q <= gpp_pkg::RST_BYTE;
			sel0_q <= gpp_pkg::RST_BYTE;
			sel1_q <= gpp_pkg::RST_BYTE;
			irq_mask_q <= 2'h0;
		end else if (wr) begin
			if (eff == gpp_pkg::OFS_IRQ_LEVEL_CTRL) begin
				lvl_ctrl_q <= wdata & gpp_pkg::IRQ_LEVEL_CTRL_RW; // RULE3 RULE12
			end
			if (eff == gpp_pkg::OFS_IRQ0_PIN_SELECT) begin
				sel0_q <= wdata;
			end
			if (eff == gpp_pkg::OFS_IRQ1_PIN_SELECT) begin
				sel1_q <= wdata;
			end
			if (eff == gpp_pkg::OFS_IRQ_MASK) begin
				irq_mask_q <= wdata[1:0];
			end
		end
	end

	// sticky flags, cleared by writing one; a same-cycle event beats the clear
	always_comb begin
		hit[0] = |(sel0_q & pin_ev); // RULE4
		hit[1] = |(sel1_q & pin_ev); // RULE5
		flags_d = flags_q;
		if (wr && eff == gpp_pkg::OFS_IRQ_FLAGS) begin
			flags_d = flags_q & ~wdata[1:0];
		end
		flags_d = flags_d | hit;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			flags_q <= 2'h0;
		end else begin
			flags_q <= flags_d;
		end
	end

	// level outputs to the interrupt controller and the summary line
	always_ff @(posedge clk) begin
		if (rst) begin
			irq0_level_q <= gpp_pkg::RST_LEVEL;
			irq1_level_q <= gpp_pkg::RST_LEVEL;
			irq_q <= 1'b0;
		end else begin
			irq0_level_q <= flags_d[0] ? lvl_ctrl_q[gpp_pkg::LVL0_LSB +: 2] : gpp_pkg::RST_LEVEL; // RULE13
			irq1_level_q <= flags_d[1] ? lvl_ctrl_q[gpp_pkg::LVL1_LSB +: 2] : gpp_pkg::RST_LEVEL; // RULE13
			irq_q <= |(flags_d & irq_mask_q);
		end
	end

	// per-pin control registers with group write
	always_ff @(posedge clk) begin
		if (rst) begin
			for (int n = 0; n < 8; n++) begin
				pin_ctrl_q[n] <= gpp_pkg::RST_BYTE;
			end
		end else if (pin_wr) begin
			for (int n = 0; n < 8; n++) begin
				if (mpc_q != 8'h00 ? mpc_q[n] : (pin_idx == n[2:0])) begin // RULE7
					pin_ctrl_q[n] <= wdata;
				end
			end
		end
	end

	// port configuration: one-shot mask and virtual map
	always_ff @(posedge clk) begin
		if (rst) begin
			mpc_q <= gpp_pkg::RST_BYTE;
			vmap_a_q <= gpp_pkg::RST_BYTE;
			vmap_b_q <= gpp_pkg::RST_BYTE;
		end else begin
			if (pin_wr) begin
				mpc_q <= gpp_pkg::RST_BYTE; // RULE8
			end else if (wr && eff == gpp_pkg::OFS_MULTI_PIN_MASK) begin
				mpc_q <= wdata;
			end
			if (wr && eff == gpp_pkg::OFS_VMAP_A) begin
				vmap_a_q <= wdata; // RULE9
			end
			if (wr && eff == gpp_pkg::OFS_VMAP_B) begin
				vmap_b_q <= wdata; // RULE9
			end
		end
	end

	// read data one cycle after the strobe; unmapped reads give zero
	always_ff @(posedge clk) begin
		if (rst) begin
			rdata_q <= gpp_pkg::RST_BYTE;
		end else if (rd) begin
			if (eff[7:3] == gpp_pkg::OFS_PIN_CTRL[7:3]) begin
				rdata_q <= pin_ctrl_q[pin_idx];
			end else begin
				unique case (eff)
					gpp_pkg::OFS_DIR: rdata_q <= dir_q;
					gpp_pkg::OFS_OUT: rdata_q <= out_q;
					gpp_pkg::OFS_IN: rdata_q <= in_q; // RULE1
					gpp_pkg::OFS_IRQ_LEVEL_CTRL: rdata_q <= lvl_ctrl_q; // RULE12
					gpp_pkg::OFS_IRQ0_PIN_SELECT: rdata_q <= sel0_q;
					gpp_pkg::OFS_IRQ1_PIN_SELECT: rdata_q <= sel1_q;
					gpp_pkg::OFS_IRQ_FLAGS: rdata_q <= {6'h00, flags_q};
					gpp_pkg::OFS_IRQ_MASK: rdata_q <= {6'h00, irq_mask_q};
					gpp_pkg::OFS_MULTI_PIN_MASK: rdata_q <= mpc_q;
					gpp_pkg::OFS_VMAP_A: rdata_q <= vmap_a_q;
					gpp_pkg::OFS_VMAP_B: rdata_q <= vmap_b_q;
					default: rdata_q <= gpp_pkg::RST_BYTE;
				endcase
			end
		end else begin
			rdata_q <= gpp_pkg::RST_BYTE;
		end
	end

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	logic [7:0] off_vec;
	always_comb begin
		for (int n = 0; n < 8; n++) begin
			off_vec[n] = pin_ctrl_q[n][gpp_pkg::SENSE_W-1:0] == gpp_pkg::GPP_SENSE_OFF;
		end
	end

	chk_in_disabled_zero: assert property (##1 (in_q & $past(off_vec)) == 8'h00) // RULE2
		else $error("disabled pin shows a level");
	chk_in_value_read: assert property (rd && addr == gpp_pkg::OFS_IN |=> rdata_q == $past(in_q)) // RULE1
		else $error("input value read wrong");
	chk_in_follow_pin: assert property (sync2_q[0] == sync3_q[0] && !off_vec[0] |=> in_q[0] == $past(sync3_q[0])) // RULE1
		else $error("input value did not follow pin");
	chk_irq0_source: assert property ($rose(flags_q[0]) |-> $past(|(sel0_q & pin_ev))) // RULE4 RULE6
		else $error("irq0 flag set without selected event");
	chk_irq1_source: assert property ($rose(flags_q[1]) |-> $past(|(sel1_q & pin_ev))) // RULE5 RULE6
		else $error("irq1 flag set without selected event");
	chk_level_out_zero: assert property (lvl_ctrl_q[1:0] == 2'h0 ##1 lvl_ctrl_q[1:0] == 2'h0 |-> irq0_level_q == 2'h0) // RULE3 RULE13
		else $error("irq0 raised with zero level");
	chk_level_out_on: assert property (flags_q[1] && lvl_ctrl_q[3:2] != 2'h0 && !wr |=> irq1_level_q == $past(lvl_ctrl_q[3:2])) // RULE13
		else $error("irq1 level not presented");
	chk_mpc_auto_clear: assert property (pin_wr |=> mpc_q == 8'h00) // RULE8
		else $error("multi-pin mask not cleared");
	chk_mpc_group_only: assert property (pin_wr && mpc_q != 8'h00 && !mpc_q[0] |=> $stable(pin_ctrl_q[0])) // RULE7
		else $error("unmasked pin control changed");
	chk_ctrl_upper_zero: assert property (lvl_ctrl_q[7:4] == 4'h0) // RULE12
		else $error("reserved level bits set");
	chk_vport_in_read: assert property (rd && addr == (gpp_pkg::OFS_VPORT | gpp_pkg::VP_IN) // RULE11 RULE14
		&& vmap_a_q[3:0] == 4'h0 |=> rdata_q == $past(in_q))
		else $error("virtual input read wrong");
	chk_vport_dir_write: assert property (wr && addr == gpp_pkg::OFS_VPORT // RULE10 RULE11
		&& vmap_a_q[3:0] == 4'h0 |=> pin_oe_q == $past(wdata))
		else $error("virtual direction write lost");

	// flag and level paths end to end; a set must win over a same-cycle clear
	chk_flag0_set: assert property (hit[0] // RULE4 RULE6
		|=> flags_q[0])
		else $error("irq0 flag missed a selected event");
	chk_flag1_set: assert property (hit[1] // RULE5 RULE6
		|=> flags_q[1])
		else $error("irq1 flag missed a selected event");
	chk_rise_sets_flag: assert property (pin_ctrl_q[0][gpp_pkg::SENSE_W-1:0] == gpp_pkg::GPP_SENSE_RISE // RULE6
		&& sel0_q[0] && in_d[0] && !in_q[0]
		|=> flags_q[0])
		else $error("rising pin did not set irq0 flag");
	chk_flag_clear: assert property (wr && addr == gpp_pkg::OFS_IRQ_FLAGS && wdata[0] && !hit[0] // RULE13
		|=> !flags_q[0])
		else $error("irq0 flag not cleared by one");
	chk_level0_on: assert property (flags_q[0] && lvl_ctrl_q[1:0] != 2'h0 && !wr // RULE3 RULE13
		|=> irq0_level_q == $past(lvl_ctrl_q[1:0]))
		else $error("irq0 level not presented");
	chk_level1_zero: assert property (lvl_ctrl_q[3:2] == 2'h0 // RULE3 RULE13
		|=> irq1_level_q == 2'h0)
		else $error("irq1 raised with zero level");
	chk_level1_no_flag: assert property (!flags_d[1] // RULE13
		|=> irq1_level_q == 2'h0)
		else $error("irq1 raised without its flag");
	chk_irq_summary: assert property ((flags_d & irq_mask_q) != 2'h0 // RULE13
		|=> irq_q)
		else $error("summary interrupt missing");
	chk_no_event_disabled: assert property ((pin_ev & off_vec) == 8'h00) // RULE2
		else $error("disabled pin raised an event");
	chk_group_lands: assert property (pin_wr && mpc_q[0] // RULE7
		|=> pin_ctrl_q[0] == $past(wdata))
		else $error("masked pin control not written");
	chk_single_lands: assert property (pin_wr && mpc_q == 8'h00 && pin_idx == 3'h0 // RULE6
		|=> pin_ctrl_q[0] == $past(wdata))
		else $error("pin control write lost");
	chk_ctrl_read: assert property (rd && addr == gpp_pkg::OFS_PIN_CTRL // RULE6
		|=> rdata_q == $past(pin_ctrl_q[0]))
		else $error("pin control read wrong");
	chk_vmap_read: assert property (rd && addr == gpp_pkg::OFS_VMAP_A // RULE9
		|=> rdata_q == $past(vmap_a_q))
		else $error("map register read wrong");
	chk_vport_foreign: assert property (wr && addr == gpp_pkg::OFS_VPORT // RULE14
		&& vmap_a_q[3:0] != gpp_pkg::PORT_INDEX |=> $stable(dir_q))
		else $error("foreign virtual write reached this port");
	chk_vport_flag_clear: assert property (wr && addr == (gpp_pkg::OFS_VPORT | gpp_pkg::VP_FLAGS) // RULE11
		&& vmap_a_q[3:0] == 4'h0 && wdata[0] && !hit[0] |=> !flags_q[0])
		else $error("virtual flag clear lost");
	chk_rdata_idle: assert property (!rd // RULE1
		|=> rdata_q == 8'h00)
		else $error("read data did not return to zero");

	cov_group_write: cover property (pin_wr && mpc_q != 8'h00);
	cov_irq0_raised: cover property ($rose(irq0_level_q != 2'h0));
	cov_vport_flag_clear: cover property (wr && addr == (gpp_pkg::OFS_VPORT | gpp_pkg::VP_FLAGS) && flags_q != 2'h0);
	cov_pin_disabled: cover property (off_vec != 8'h00 && rd && addr == gpp_pkg::OFS_IN);
	cov_irq1_raised: cover property ($rose(irq1_level_q != 2'h0));
endmodule

// ### testbench/gpp_pin_model.sv
// far-side model: outside drivers on the eight port pins
`timescale 1ns/1ps
module gpp_pin_model (
	// level the outside world applies
	input wire logic [7:0] ext_level,
	// port side
	input wire logic [7:0] pin_out_q,
	input wire logic [7:0] pin_oe_q,
	output logic [7:0] pin_in
);
	// a pin the port drives shows its own output, so the outside driver must yield there
	assign pin_in = (pin_oe_q & pin_out_q) | (~pin_oe_q & ext_level);
endmodule

// ### testbench/gpp_port_test.sv
// self-checking bench for the general-purpose port
`timescale 1ns/1ps
module gpp_port_test;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [7:0] ext = 8'h00;
	logic [7:0] rdata_q;
	logic [7:0] pin_out_q;
	logic [7:0] pin_oe_q;
	logic [7:0] pin_in;
	logic [1:0] irq0_level_q;
	logic [1:0] irq1_level_q;
	logic irq_q;
	logic [7:0] rv_addr [7] = '{8'h40, 8'h42, 8'h43, 8'h08, 8'h09, 8'h0A, 8'h0B};
	int err_total = 0;
	int total_checks = 0;
	always #12.5 clk = ~clk;
	gpp_port gpp_port_inst (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata_q(rdata_q), .pin_in(pin_in), .pin_out_q(pin_out_q), .pin_oe_q(pin_oe_q),
		.irq0_level_q(irq0_level_q), .irq1_level_q(irq1_level_q), .irq_q(irq_q));
	gpp_pin_model gpp_pin_model_inst (.ext_level(ext), .pin_out_q(pin_out_q), .pin_oe_q(pin_oe_q),
		.pin_in(pin_in));
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe, so sample just past that edge
	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		check($sformatf("reg %h", a), rdata_q, exp);
	endtask
	// pins pass a three-flop synchroniser before the input value register
	task automatic settle();
		repeat (6) @(posedge clk);
		#1;
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		#(25 * 3000);
		err_total++;
		conclude();
	end
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		foreach (rv_addr[i]) rchk(rv_addr[i], 8'h00);
		wr_reg(8'h09, 8'hFF);
		rchk(8'h09, 8'h0F);
		wr_reg(8'h0A, 8'hA5);
		wr_reg(8'h0B, 8'h5A);
		rchk(8'h0A, 8'hA5);
		rchk(8'h0B, 8'h5A);
		wr_reg(8'h42, 8'h21);
		wr_reg(8'h43, 8'h43);
		rchk(8'h42, 8'h21);
		rchk(8'h43, 8'h43);
		wr_reg(8'hFF, 8'h55);
		rchk(8'hFF, 8'h00);
		wr_reg(8'h08, 8'h3C);
		foreach (rv_addr[i]) wr_reg(rv_addr[i], 8'h00);
		ext <= 8'hA5;
		settle();
		rchk(8'h08, 8'hA5);
		$display("test registers done");
		wr_reg(8'h40, 8'h0F);
		wr_reg(8'h16, 8'h07);
		rchk(8'h40, 8'h00);
		for (int i = 0; i < 8; i++) rchk(8'(8'h10 + i), (i < 4) ? 8'h07 : 8'h00);
		settle();
		rchk(8'h08, 8'hA0);
		wr_reg(8'h40, 8'h0F);
		wr_reg(8'h10, 8'h00);
		$display("test multi-pin done");
		wr_reg(8'h10, 8'h01);
		wr_reg(8'h11, 8'h02);
		wr_reg(8'h0A, 8'h01);
		wr_reg(8'h0B, 8'h02);
		wr_reg(8'h09, 8'h09);
		wr_reg(8'h0C, 8'h03);
		ext <= 8'hA0;
		settle();
		check("irq0 level", {6'h00, irq0_level_q}, 8'h00);
		check("irq1 level", {6'h00, irq1_level_q}, 8'h00);
		ext <= 8'hA3;
		settle();
		check("irq0 level", {6'h00, irq0_level_q}, 8'h01);
		check("irq1 level", {6'h00, irq1_level_q}, 8'h00);
		ext <= 8'hA1;
		settle();
		check("irq1 level", {6'h00, irq1_level_q}, 8'h02);
		check("irq sum", {7'h00, irq_q}, 8'h00);
		wr_reg(8'h0D, 8'h02);
		settle();
		check("irq sum", {7'h00, irq_q}, 8'h01);
		rchk(8'h0C, 8'h03);
		wr_reg(8'h0C, 8'h01);
		settle();
		check("irq0 level", {6'h00, irq0_level_q}, 8'h00);
		wr_reg(8'h09, 8'h01);
		settle();
		check("irq1 level", {6'h00, irq1_level_q}, 8'h00);
		wr_reg(8'h0C, 8'h03);
		wr_reg(8'h0D, 8'h00);
		settle();
		check("irq sum", {7'h00, irq_q}, 8'h00);
		for (int i = 0; i < 6; i++) wr_reg(8'(8'h09 + i), 8'h00);
		wr_reg(8'h10, 8'h00);
		wr_reg(8'h11, 8'h00);
		$display("test interrupts done");
		wr_reg(8'h50, 8'h3C);
		#1;
		check("direction", pin_oe_q, 8'h3C);
		rchk(8'h00, 8'h3C);
		wr_reg(8'h55, 8'h0F);
		#1;
		check("output", pin_out_q, 8'h0F);
		rchk(8'h04, 8'h0F);
		settle();
		rchk(8'h56, 8'h8D);
		rchk(8'h08, 8'h8D);
		wr_reg(8'h0A, 8'h80);
		ext <= 8'h21;
		settle();
		rchk(8'h5B, 8'h01);
		wr_reg(8'h5F, 8'h01);
		rchk(8'h0C, 8'h00);
		wr_reg(8'h0A, 8'h00);
		wr_reg(8'h42, 8'h10);
		wr_reg(8'h54, 8'hFF);
		#1;
		check("direction", pin_oe_q, 8'h3C);
		rchk(8'h54, 8'h00);
		rchk(8'h50, 8'h3C);
		$display("test virtual ports done");
		conclude();
	end
endmodule
